// *** rtl/pin_ctl_regs.svh ***
// pin_ctl_regs.svh: offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from rtl/ files
`ifndef PIN_CTL_REGS_SVH
`define PIN_CTL_REGS_SVH
// register indices (byte address = index)
`define REG_CTRL        4'h0
`define REG_STATUS      4'h1
`define REG_CCW         4'h2
`define REG_RESET_INFO  4'h3
// control register fields
`define CTRL_BUS_CLK_OFF   0
`define CTRL_BUFCLK_EN     1
`define CTRL_EDGE_SENSE    2
`define CTRL_INT_ACK       3
`define CTRL_STOP          4
// condition code word fields
`define CCW_GEN_MASK       0
`define CCW_PWR_MASK       1
// status fields
`define STAT_MASK_PEND     0
`define STAT_NMI_PEND      1
`define STAT_SINGLE_CHIP   2
// reset info fields
`define RINFO_EXTERNAL     0
`define RINFO_VALID        1
// reset values
`define CTRL_RESET         8'h00
`define CCW_RESET          8'h03
// timing: oscillator divide and classification threshold in bus_clk cycles
`define OSC_DIV            4
`define RESET_CLASS_CYC    2
`define OSC_CNT_W          2
`endif

// *** rtl/pin_ctl_pkg.sv ***
// pin_ctl_pkg.sv: shared types of the pin control block
// assumes nothing beyond the header of constants
package pin_ctl_pkg;
    typedef enum logic [1:0] {
        RST_IDLE  = 2'b00,
        RST_HOLD  = 2'b01,
        RST_COUNT = 2'b10
    } reset_state_type;
endpackage

// *** rtl/int_sense_if.sv ***
// int_sense_if.sv: carries interrupt sensing controls and results
// assumes one clock domain shared by both ends
`timescale 1ns/100ps
`default_nettype none
interface int_sense_if;
    logic edge_mode;
    logic ack;
    logic gen_mask;
    logic pwr_mask;
    logic req_pend;
    logic nmi_pend;
    modport ctl (output edge_mode, output ack, output gen_mask, output pwr_mask,
                 input req_pend, input nmi_pend);
    modport sense (input edge_mode, input ack, input gen_mask, input pwr_mask,
                   output req_pend, output nmi_pend);
endinterface
`default_nettype wire

// *** rtl/int_sense.sv ***
// int_sense.sv: synchronises and senses the two interrupt request pins
// assumes pins are asynchronous and active low, clock is core_clk
`timescale 1ns/100ps
`default_nettype none
module int_sense (
    input  wire logic     core_clk,
    input  wire logic     rst_sync_n,
    input  wire logic     maskable_int_req_n,
    input  wire logic     nonmaskable_int_req_n,
    int_sense_if.sense    bus
);
    logic [1:0] sync1_q, sync2_q, prev_q;
    logic       latch_q, latch_d;
    logic       req_pend_q, req_pend_d, nmi_pend_q, nmi_pend_d;
    logic       fall;

    // two-stage synchronisers, first stage read by the second and by a_sync_delay
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sync1_q <= 2'h3;
            sync2_q <= 2'h3;
            prev_q  <= 2'h3;
        end else begin
            sync1_q <= {nonmaskable_int_req_n, maskable_int_req_n};
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    assign fall = prev_q[0] && !sync2_q[0];

    // edge latch held until acknowledged; set wins over ack
    always_comb begin
        latch_d = latch_q;
        if (bus.ack) begin
            latch_d = 1'b0;
        end
        if (fall) begin
            latch_d = 1'b1;
        end
        req_pend_d = (bus.edge_mode ? latch_q : !sync2_q[0]) && !bus.gen_mask;
        nmi_pend_d = !sync2_q[1] && !bus.pwr_mask;
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            latch_q    <= 1'b0;
            req_pend_q <= 1'b0;
            nmi_pend_q <= 1'b0;
        end else begin
            latch_q    <= latch_d;
            req_pend_q <= req_pend_d;
            nmi_pend_q <= nmi_pend_d;
        end
    end

    assign bus.req_pend = req_pend_q;
    assign bus.nmi_pend = nmi_pend_q;

    property p_mask_blocks;
        @(posedge core_clk) disable iff (!rst_sync_n)
        bus.gen_mask |=> !req_pend_q;
    endproperty
    a_mask_blocks: assert property (p_mask_blocks) else $error("masked request pending");

    property p_level_req;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (!bus.edge_mode && !bus.gen_mask && !sync2_q[0]) |=> req_pend_q;
    endproperty
    a_level_req: assert property (p_level_req) else $error("level request missed");

    property p_nmi_level;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (!bus.pwr_mask && !sync2_q[1]) |=> nmi_pend_q;
    endproperty
    a_nmi_level: assert property (p_nmi_level) else $error("nmi level missed");

    property p_sync_delay;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (!bus.edge_mode && !bus.gen_mask && sync2_q[0] && !sync1_q[0]) |=> !req_pend_q;
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("sync chain skipped");
endmodule // int_sense
`default_nettype wire

// *** rtl/pin_ctl.sv ***
// pin_ctl.sv: reset pin, bus clock, buffered clock and interrupt pin logic
// assumes osc_clk_in is sampled as an asynchronous pin, core_clk at 100 MHz
`timescale 1ns/100ps
`default_nettype none
`include "pin_ctl_regs.svh"
module pin_ctl
    import pin_ctl_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       reset_pin_in,
    output logic            reset_pin_out,
    output logic            reset_pin_oe,
    input  wire logic       monitor_fail,
    input  wire logic       watchdog_timer_fail,
    input  wire logic       osc_clk_in,
    input  wire logic       single_chip_mode,
    output logic            bus_clk,
    output logic            bus_clk_oe,
    output logic            buffered_clock_out,
    input  wire logic       maskable_int_req_n,
    input  wire logic       nonmaskable_int_req_n,
    output logic            chip_init_n,
    output logic            mask_int_pending,
    output logic            nmi_pending,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata
);
    logic [1:0] rst_sync_q;
    logic       rst_sync_n;
    logic [1:0] pin_sync_q, mode_sync_q;
    logic [2:0] osc_sync_q;
    logic       pin_lo, osc_rise, single_chip;
    logic [`OSC_CNT_W-1:0] osc_cnt_q, osc_cnt_d;
    logic       bus_clk_q, bus_clk_d, bus_clk_oe_q, bus_clk_oe_d;
    logic       bufclk_q, bufclk_d, bus_tick;
    logic [7:0] ctrl_q, ctrl_d, ccw_q, ccw_d, rdata_q, rdata_d;
    logic       pwr_cleared_q, pwr_cleared_d;
    reset_state_type rst_state_q, rst_state_d;
    logic [2:0] rst_cnt_q, rst_cnt_d;
    logic       ext_q, ext_d, rinfo_valid_q, rinfo_valid_d;
    logic       drive_q, drive_d, init_n_q, init_n_d;
    logic       req_q, nmi_q;
    int_sense_if isif ();

    // reset release through two flip-flops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_sync_q[1];

    // pin synchronisers; stage zero feeds only stage one
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pin_sync_q  <= 2'h3;
            mode_sync_q <= 2'h0;
            osc_sync_q  <= 3'h0;
        end else begin
            pin_sync_q  <= {pin_sync_q[0], reset_pin_in};
            mode_sync_q <= {mode_sync_q[0], single_chip_mode};
            osc_sync_q  <= {osc_sync_q[1:0], osc_clk_in};
        end
    end
    assign pin_lo      = !pin_sync_q[1];
    assign single_chip = mode_sync_q[1];
    assign osc_rise = osc_sync_q[1] && !osc_sync_q[2];
    assign bus_tick = osc_rise && (osc_cnt_q == `OSC_CNT_W'(`OSC_DIV - 1));

    // oscillator divide by four: two periods low (address), two high (data)
    always_comb begin
        osc_cnt_d    = osc_cnt_q;
        bus_clk_d    = bus_clk_q;
        bufclk_d     = bufclk_q;
        bus_clk_oe_d = !(ctrl_q[`CTRL_BUS_CLK_OFF] && single_chip);
        if (osc_rise && !ctrl_q[`CTRL_STOP]) begin
            osc_cnt_d = osc_cnt_q + `OSC_CNT_W'(1);
            bus_clk_d = osc_cnt_d[`OSC_CNT_W-1];
            bufclk_d  = !bufclk_q;
        end
        if (ctrl_q[`CTRL_STOP]) begin
            bus_clk_d = 1'b0;
            bufclk_d  = 1'b0;
        end
        if (!ctrl_q[`CTRL_BUFCLK_EN]) begin
            bufclk_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            osc_cnt_q    <= '0;
            bus_clk_q    <= 1'b0;
            bufclk_q     <= 1'b0;
            bus_clk_oe_q <= 1'b1;
        end else begin
            osc_cnt_q    <= osc_cnt_d;
            bus_clk_q    <= bus_clk_d;
            bufclk_q     <= bufclk_d;
            bus_clk_oe_q <= bus_clk_oe_d;
        end
    end

    // reset pin: failure drive, chip init and internal/external classification
    always_comb begin
        rst_state_d   = rst_state_q;
        rst_cnt_d     = rst_cnt_q;
        ext_d         = ext_q;
        rinfo_valid_d = rinfo_valid_q;
        drive_d       = drive_q;
        init_n_d      = init_n_q;
        case (rst_state_q)
            RST_IDLE: begin
                init_n_d = 1'b1;
                if (monitor_fail || watchdog_timer_fail) begin
                    drive_d     = 1'b1;
                    init_n_d    = 1'b0;
                    rst_cnt_d   = '0;
                    rst_state_d = RST_HOLD;
                end else if (pin_lo) begin
                    init_n_d    = 1'b0;
                    rst_cnt_d   = '0;
                    rst_state_d = RST_COUNT;
                end
            end
            RST_HOLD: begin
                // keep driving until the pin is seen low at a bus tick
                if (bus_tick && pin_lo) begin
                    drive_d     = 1'b0;
                    rst_state_d = RST_COUNT;
                end
            end
            RST_COUNT: begin
                init_n_d = 1'b0;
                if (bus_tick && rst_cnt_q != 3'h7) begin
                    rst_cnt_d = rst_cnt_q + 3'h1;
                end
                if (!pin_lo) begin
                    ext_d         = (rst_cnt_q >= 3'(`RESET_CLASS_CYC));
                    rinfo_valid_d = 1'b1;
                    init_n_d      = 1'b1;
                    rst_state_d   = RST_IDLE;
                end
            end
            default: begin
                rst_state_d = RST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rst_state_q   <= RST_IDLE;
            rst_cnt_q     <= '0;
            ext_q         <= 1'b0;
            rinfo_valid_q <= 1'b0;
            drive_q       <= 1'b0;
            init_n_q      <= 1'b0;
        end else begin
            rst_state_q   <= rst_state_d;
            rst_cnt_q     <= rst_cnt_d;
            ext_q         <= ext_d;
            rinfo_valid_q <= rinfo_valid_d;
            drive_q       <= drive_d;
            init_n_q      <= init_n_d;
        end
    end

    // register writes and reads; unmapped reads return zero
    always_comb begin
        ctrl_d        = ctrl_q;
        ccw_d         = ccw_q;
        pwr_cleared_d = pwr_cleared_q;
        rdata_d       = 8'h00;
        ctrl_d[`CTRL_INT_ACK] = 1'b0;
        if (!init_n_q) begin
            ctrl_d        = `CTRL_RESET;
            ccw_d         = `CCW_RESET;
            pwr_cleared_d = 1'b0;
        end else if (reg_wr) begin
            case (reg_addr)
                `REG_CTRL: ctrl_d = reg_wdata;
                `REG_CCW: begin
                    ccw_d[`CCW_GEN_MASK] = reg_wdata[`CCW_GEN_MASK];
                    ccw_d[`CCW_PWR_MASK] = reg_wdata[`CCW_PWR_MASK] && !pwr_cleared_q;
                    if (!reg_wdata[`CCW_PWR_MASK]) begin
                        pwr_cleared_d = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                `REG_CTRL:   rdata_d = ctrl_q;
                `REG_STATUS: rdata_d = {5'h00, single_chip, nmi_q, req_q};
                `REG_CCW:    rdata_d = ccw_q;
                `REG_RESET_INFO: rdata_d = {6'h00, rinfo_valid_q, ext_q};
                default:     rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ctrl_q        <= `CTRL_RESET;
            ccw_q         <= `CCW_RESET;
            pwr_cleared_q <= 1'b0;
            rdata_q       <= 8'h00;
        end else begin
            ctrl_q        <= ctrl_d;
            ccw_q         <= ccw_d;
            pwr_cleared_q <= pwr_cleared_d;
            rdata_q       <= rdata_d;
        end
    end

    // interrupt sensing block
    assign isif.edge_mode = ctrl_q[`CTRL_EDGE_SENSE];
    assign isif.ack       = ctrl_q[`CTRL_INT_ACK];
    assign isif.gen_mask  = ccw_q[`CCW_GEN_MASK];
    assign isif.pwr_mask  = ccw_q[`CCW_PWR_MASK];
    assign req_q          = isif.req_pend;
    assign nmi_q          = isif.nmi_pend;

    int_sense u_int_sense (
        .core_clk              (core_clk),
        .rst_sync_n            (rst_sync_n),
        .maskable_int_req_n    (maskable_int_req_n),
        .nonmaskable_int_req_n (nonmaskable_int_req_n),
        .bus                   (isif)
    );

    assign reset_pin_out      = 1'b0;
    assign reset_pin_oe       = drive_q;
    assign bus_clk            = bus_clk_q;
    assign bus_clk_oe         = bus_clk_oe_q;
    assign buffered_clock_out = bufclk_q;
    assign chip_init_n        = init_n_q;
    assign mask_int_pending   = req_q;
    assign nmi_pending        = nmi_q;
    assign reg_rdata          = rdata_q;

    property p_fail_drive;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (rst_state_q == RST_IDLE && (monitor_fail || watchdog_timer_fail)) |=> reset_pin_oe;
    endproperty
    a_fail_drive: assert property (p_fail_drive) else $error("failure not driven");

    property p_pin_init;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (rst_state_q == RST_IDLE && pin_lo) |=> !chip_init_n;
    endproperty
    a_pin_init: assert property (p_pin_init) else $error("pin reset ignored");

    property p_pwr_sticky;
        @(posedge core_clk) disable iff (!rst_sync_n)
        (pwr_cleared_q && init_n_q) |-> !ccw_q[`CCW_PWR_MASK];
    endproperty
    a_pwr_sticky: assert property (p_pwr_sticky) else $error("power mask set again");

    property p_stop_halt;
        @(posedge core_clk) disable iff (!rst_sync_n)
        ctrl_q[`CTRL_STOP] |=> (!bus_clk && !buffered_clock_out);
    endproperty
    a_stop_halt: assert property (p_stop_halt) else $error("clock runs in stop");

    property p_oe_mode;
        @(posedge core_clk) disable iff (!rst_sync_n)
        !single_chip |=> bus_clk_oe;
    endproperty
    a_oe_mode: assert property (p_oe_mode) else $error("bus clock off outside single chip");

    property p_bufclk_en;
        @(posedge core_clk) disable iff (!rst_sync_n)
        !ctrl_q[`CTRL_BUFCLK_EN] |=> !buffered_clock_out;
    endproperty
    a_bufclk_en: assert property (p_bufclk_en) else $error("buffered clock not gated");
endmodule // pin_ctl
`default_nettype wire

// *** verification/reset_int_partner.sv ***
// reset_int_partner.sv: external reset circuit and wire-or interrupt sources
// assumes one clock, pull-ups on all three lines, requests given as pulses
`timescale 1ns/100ps
`default_nettype none
module reset_int_partner (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       ext_reset_req,
    input  wire logic [1:0] irq_src_req,
    input  wire logic [1:0] irq_src_ack,
    input  wire logic       nmi_src_req,
    input  wire logic       nmi_src_ack,
    input  wire logic       dut_reset_out,
    input  wire logic       dut_reset_oe,
    output logic            reset_line,
    output logic            irq_line,
    output logic            nmi_line
);
    logic [1:0] irq_hold_q;
    logic [1:0] irq_hold_d;
    logic       nmi_hold_q;
    logic       nmi_hold_d;
    // each source keeps its line low until acknowledged
    always_comb begin
        irq_hold_d = (irq_hold_q | irq_src_req) & ~irq_src_ack;
        nmi_hold_d = (nmi_hold_q | nmi_src_req) & ~nmi_src_ack;
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_hold_q <= 2'h0;
            nmi_hold_q <= 1'b0;
        end else begin
            irq_hold_q <= irq_hold_d;
            nmi_hold_q <= nmi_hold_d;
        end
    end
    // open-drain drivers on pulled-up lines, never contending
    assign irq_line   = ~|irq_hold_q;
    assign nmi_line   = ~nmi_hold_q;
    assign reset_line = ~(ext_reset_req | (dut_reset_oe & ~dut_reset_out));
endmodule // reset_int_partner
`default_nettype wire

// *** verification/testbench.sv ***
// testbench.sv: register and pin level tests of the pin control block
// assumes the partner model drives the reset pin and interrupt lines
`timescale 1ns/100ps
`default_nettype none
`include "pin_ctl_regs.svh"
`define CHECK(nm, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module testbench;
    localparam int OSC_HALF_NS = 40;
    localparam int BUS_HALF    = `OSC_DIV * OSC_HALF_NS / 10;
    localparam int TIMEOUT     = 40000;
    logic       core_clk, rst_n, osc_clk_in, monitor_fail, watchdog_timer_fail;
    logic       single_chip_mode, reset_pin_out, reset_pin_oe, bus_clk, bus_clk_oe;
    logic       buffered_clock_out, chip_init_n, mask_int_pending, nmi_pending;
    logic       reset_line, irq_line, nmi_line, ext_reset_req, nmi_src_req, nmi_src_ack;
    logic       reg_wr, reg_rd, bufclk_prev, busclk_prev;
    logic [1:0] irq_src_req, irq_src_ack;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rd;
    int         miscompares, check_count, cycle_count, buf_tog, bus_tog, snap, hi, lo, i, k;

    pin_ctl dut (.core_clk(core_clk), .rst_n(rst_n), .reset_pin_in(reset_line),
        .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
        .monitor_fail(monitor_fail), .watchdog_timer_fail(watchdog_timer_fail),
        .osc_clk_in(osc_clk_in), .single_chip_mode(single_chip_mode), .bus_clk(bus_clk),
        .bus_clk_oe(bus_clk_oe), .buffered_clock_out(buffered_clock_out),
        .maskable_int_req_n(irq_line), .nonmaskable_int_req_n(nmi_line),
        .chip_init_n(chip_init_n), .mask_int_pending(mask_int_pending),
        .nmi_pending(nmi_pending), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    reset_int_partner far_side (.core_clk(core_clk), .rst_n(rst_n),
        .ext_reset_req(ext_reset_req), .irq_src_req(irq_src_req),
        .irq_src_ack(irq_src_ack), .nmi_src_req(nmi_src_req), .nmi_src_ack(nmi_src_ack),
        .dut_reset_out(reset_pin_out), .dut_reset_oe(reset_pin_oe),
        .reset_line(reset_line), .irq_line(irq_line), .nmi_line(nmi_line));

    // core clock and an oscillator of unrelated phase
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        osc_clk_in = 1'b0;
        #3;
        forever #(OSC_HALF_NS) osc_clk_in = ~osc_clk_in;
    end
    // toggle counters of the clock outputs and the hang limit
    always @(posedge core_clk) begin
        bufclk_prev <= buffered_clock_out;
        busclk_prev <= bus_clk;
        if (buffered_clock_out !== bufclk_prev) buf_tog <= buf_tog + 1;
        if (bus_clk !== busclk_prev) bus_tog <= bus_tog + 1;
        cycle_count <= cycle_count + 1;
        if (cycle_count == TIMEOUT) begin
            miscompares++;
            $display("timeout after %0d cycles", cycle_count);
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a, input logic [7:0] e, input string nm);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        `CHECK(nm, e, reg_rdata)
    endtask
    task automatic wait_init(input logic lvl);
        for (i = 0; i < 600 && chip_init_n !== lvl; i++) tick(1);
    endtask
    task automatic measure_bus_clk();
        hi = 0;
        lo = 0;
        for (i = 0; i < 100 && bus_clk !== 1'b0; i++) tick(1);
        for (i = 0; i < 100 && bus_clk !== 1'b1; i++) tick(1);
        while (bus_clk === 1'b1 && hi < 100) begin tick(1); hi++; end
        while (bus_clk === 1'b0 && lo < 100) begin tick(1); lo++; end
    endtask

    // main sequence
    initial begin
        rst_n = 1'b0;
        monitor_fail = 1'b0;
        watchdog_timer_fail = 1'b0;
        single_chip_mode = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        ext_reset_req = 1'b0;
        irq_src_req = 2'h0;
        irq_src_ack = 2'h0;
        nmi_src_req = 1'b0;
        nmi_src_ack = 1'b0;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        tick(5);
        reg_read(`REG_CTRL, 8'h00, "ctrl reset");
        reg_read(`REG_CCW, 8'h03, "ccw reset");
        reg_read(`REG_STATUS, 8'h00, "status reset");
        reg_read(4'h9, 8'h00, "unmapped read");
        $display("test reset values done");
        measure_bus_clk();
        `CHECK("bus clk high", BUS_HALF, hi)
        `CHECK("bus clk low", BUS_HALF, lo)
        `CHECK("bus clk driven", 1'b1, bus_clk_oe)
        reg_write(`REG_CTRL, 8'h01);
        tick(4);
        `CHECK("bus clk off refused", 1'b1, bus_clk_oe)
        @(posedge core_clk) single_chip_mode <= 1'b1;
        reg_write(`REG_CTRL, 8'h01);
        tick(4);
        `CHECK("bus clk off", 1'b0, bus_clk_oe)
        reg_read(`REG_STATUS, 8'h04, "status single chip");
        reg_write(`REG_CTRL, 8'h00);
        @(posedge core_clk) single_chip_mode <= 1'b0;
        tick(4);
        `CHECK("bus clk back on", 1'b1, bus_clk_oe)
        $display("test bus clock done");
        for (k = 0; k < 2; k++) begin
            reg_write(`REG_CTRL, k[0] ? 8'h02 : 8'h00);
            tick(8);
            snap = buf_tog;
            tick(64);
            `CHECK("buffered clock toggles", k[0] ? 8 : 0, buf_tog - snap)
        end
        reg_write(`REG_CTRL, 8'h12);
        tick(16);
        snap = bus_tog + buf_tog;
        tick(64);
        `CHECK("clocks halted in stop", 0, bus_tog + buf_tog - snap)
        reg_write(`REG_CTRL, 8'h00);
        measure_bus_clk();
        `CHECK("bus clk after stop", BUS_HALF, hi)
        $display("test clock outputs done");
        @(posedge core_clk) irq_src_req <= 2'b11;
        @(posedge core_clk) irq_src_req <= 2'b00;
        tick(6);
        `CHECK("masked request", 1'b0, mask_int_pending)
        reg_write(`REG_CCW, 8'h02);
        tick(6);
        `CHECK("unmasked request", 1'b1, mask_int_pending)
        reg_read(`REG_STATUS, 8'h01, "status pending");
        reg_write(`REG_CCW, 8'h03);
        @(posedge core_clk) irq_src_ack <= 2'b01;
        @(posedge core_clk) irq_src_ack <= 2'b00;
        tick(6);
        `CHECK("masked again", 1'b0, mask_int_pending)
        reg_write(`REG_CCW, 8'h02);
        tick(6);
        `CHECK("second source pending", 1'b1, mask_int_pending)
        @(posedge core_clk) irq_src_ack <= 2'b10;
        @(posedge core_clk) irq_src_ack <= 2'b00;
        tick(6);
        `CHECK("level request gone", 1'b0, mask_int_pending)
        reg_write(`REG_CTRL, 8'h0C);
        tick(6);
        `CHECK("edge idle after ack", 1'b0, mask_int_pending)
        @(posedge core_clk) irq_src_req <= 2'b01;
        @(posedge core_clk) irq_src_req <= 2'b00;
        @(posedge core_clk) irq_src_ack <= 2'b01;
        @(posedge core_clk) irq_src_ack <= 2'b00;
        tick(6);
        `CHECK("edge latched", 1'b1, mask_int_pending)
        reg_write(`REG_CTRL, 8'h0C);
        tick(6);
        `CHECK("edge cleared", 1'b0, mask_int_pending)
        reg_write(`REG_CTRL, 8'h00);
        $display("test maskable request done");
        @(posedge core_clk) nmi_src_req <= 1'b1;
        @(posedge core_clk) nmi_src_req <= 1'b0;
        tick(6);
        `CHECK("nmi masked", 1'b0, nmi_pending)
        reg_write(`REG_CCW, 8'h00);
        tick(6);
        `CHECK("nmi unmasked", 1'b1, nmi_pending)
        reg_write(`REG_CCW, 8'h03);
        tick(6);
        `CHECK("nmi stays unmasked", 1'b1, nmi_pending)
        reg_read(`REG_CCW, 8'h01, "power mask not set again");
        reg_write(`REG_CTRL, 8'h04);
        @(posedge core_clk) nmi_src_ack <= 1'b1;
        @(posedge core_clk) nmi_src_ack <= 1'b0;
        tick(6);
        `CHECK("nmi level only", 1'b0, nmi_pending)
        $display("test nonmaskable request done");
        for (k = 0; k < 2; k++) begin
            @(posedge core_clk);
            if (k == 0) watchdog_timer_fail <= 1'b1;
            else monitor_fail <= 1'b1;
            @(posedge core_clk);
            watchdog_timer_fail <= 1'b0;
            monitor_fail <= 1'b0;
            #1;
            `CHECK("fail drives reset pin", 1'b1, reset_pin_oe)
            `CHECK("reset pin driven low", 1'b0, reset_pin_out)
            `CHECK("fail holds chip in init", 1'b0, chip_init_n)
            wait_init(1'b1);
            reg_read(`REG_RESET_INFO, 8'h02, "internal reset kind");
        end
        reg_write(`REG_CTRL, 8'h02);
        @(posedge core_clk) ext_reset_req <= 1'b1;
        wait_init(1'b0);
        `CHECK("chip held in reset", 1'b0, chip_init_n)
        reg_write(`REG_CTRL, 8'h04);
        tick(400);
        @(posedge core_clk) ext_reset_req <= 1'b0;
        wait_init(1'b1);
        reg_read(`REG_RESET_INFO, 8'h03, "external reset kind");
        reg_read(`REG_CTRL, 8'h00, "ctrl after chip reset");
        $display("test reset pin done");
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
